/* logic/cic_map.svh */
// register offsets, field positions and reset values of the codec interrupt controller
`ifndef CIC_MAP_SVH
`define CIC_MAP_SVH

`define CIC_FLAGS_ADDR       8'h7f
`define CIC_MASKS_ADDR       8'h80
`define CIC_POLS_ADDR        8'h81
`define CIC_DEBOUNCE_ADDR    8'h82
`define CIC_SUMMARY_BIT      10
`define CIC_SHARED_PIN_BIT   9
`define CIC_SEQUENCER_BIT    8
`define CIC_GP_PIN_ONE_BIT   5
`define CIC_RIGHT_REUSED_BIT 4
`define CIC_LEFT_REUSED_BIT  3
`define CIC_LOOP_LOCK_BIT    2
`define CIC_BIAS_SHORT_BIT   1
`define CIC_BIAS_DETECT_BIT  0
`define CIC_SOURCE_BITS      16'h033f
`define CIC_MASKS_RESET      16'h033f
`define CIC_POLS_RESET       16'h0000
`define CIC_DEBOUNCE_RESET   16'h0000
`define CIC_DEBOUNCE_TIME_NS 1000
`define CIC_CLOCK_PERIOD_NS  40
`define CIC_DEBOUNCE_CYCLES  ((`CIC_DEBOUNCE_TIME_NS + `CIC_CLOCK_PERIOD_NS - 1) / `CIC_CLOCK_PERIOD_NS)

`endif

/* logic/cic_pkg.sv */
// types shared by the codec interrupt controller files
package cic_pkg;
  typedef logic [15:0] cic_word_t;   // one register word
  typedef logic [7:0]  cic_addr_t;   // register address
  // debounce filter states, one-hot
  typedef enum logic [2:0]
  {
    CIC_DB_LOW  = 3'b001,
    CIC_DB_RISE = 3'b010,
    CIC_DB_HIGH = 3'b100
  } cic_db_state_t;
endpackage : cic_pkg

/* logic/cic_debounce.sv */
// debounce filter for one interrupt source: level must hold before it passes
module cic_debounce #(
  parameter int CYCLES = 25
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic level_in,
  output logic      level_out
);
  cic_pkg::cic_db_state_t state_ff;     // filter state
  cic_pkg::cic_db_state_t nxt_state;    // next filter state
  logic [15:0]            count_ff;     // stable-time counter
  logic [15:0]            nxt_count;    // next counter value
  logic                   filt;         // filtered level

  // a rising level must stay for CYCLES clocks before it is believed; a fall passes at once
  always_comb
  begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    case (state_ff)
      cic_pkg::CIC_DB_LOW:
      begin
        nxt_count = 16'h0000;
        if (level_in)
          nxt_state = cic_pkg::CIC_DB_RISE;
      end
      cic_pkg::CIC_DB_RISE:
      begin
        // a spike drops back before the count completes
        if (!level_in)
          nxt_state = cic_pkg::CIC_DB_LOW;
        else if (count_ff >= 16'(CYCLES - 1))
          nxt_state = cic_pkg::CIC_DB_HIGH;
        else
          nxt_count = count_ff + 16'h0001;
      end
      cic_pkg::CIC_DB_HIGH:
      begin
        // release is immediate: the flag latches anyway, so only assertion matters
        if (!level_in)
          nxt_state = cic_pkg::CIC_DB_LOW;
      end
      default:
        nxt_state = cic_pkg::CIC_DB_LOW;
    endcase
  end

  // registers only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= cic_pkg::CIC_DB_LOW;
      count_ff <= 16'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
    end
  end

  assign filt      = (state_ff == cic_pkg::CIC_DB_HIGH) && level_in;
  // bypass when the filter is not enabled
  assign level_out = enable ? filt : level_in;
endmodule : cic_debounce

/* logic/cic_controller.sv */
// codec interrupt controller: latched flags, masks, polarities, debounce, register port
`include "cic_map.svh"

module cic_controller #(
  parameter int DEBOUNCE_CYCLES = `CIC_DEBOUNCE_CYCLES
) (
  input  wire logic       CLOCK,
  input  wire logic       SYS_RST,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic     [15:0] REG_RDATA,
  input  wire logic       SHARED_PIN_IN,
  input  wire logic       SHARED_PIN_IS_INPUT,
  input  wire logic       SEQUENCER_BUSY,
  input  wire logic       GP_PIN_ONE_IN,
  input  wire logic       GP_PIN_ONE_IS_INPUT,
  input  wire logic       RIGHT_REUSED_IN,
  input  wire logic       RIGHT_REUSED_ENABLE,
  input  wire logic       LEFT_REUSED_IN,
  input  wire logic       LEFT_REUSED_ENABLE,
  input  wire logic       LOOP_LOCKED,
  input  wire logic       BIAS_SHORT,
  input  wire logic       BIAS_DETECT,
  output logic            IRQ_OUT
);
  localparam cic_pkg::cic_word_t SRC = `CIC_SOURCE_BITS;  // implemented source bits

  // register state, each paired with its next value from the combinational half
  cic_pkg::cic_word_t flags_ff;      // latched status flags
  cic_pkg::cic_word_t nxt_flags;
  cic_pkg::cic_word_t masks_ff;      // mask register
  cic_pkg::cic_word_t nxt_masks;
  cic_pkg::cic_word_t pols_ff;       // polarity register
  cic_pkg::cic_word_t nxt_pols;
  cic_pkg::cic_word_t deb_ff;        // debounce enable register
  cic_pkg::cic_word_t nxt_deb;
  cic_pkg::cic_word_t rdata_ff;      // read data register
  cic_pkg::cic_word_t nxt_rdata;
  logic               irq_ff;        // registered interrupt output
  logic               nxt_irq;
  cic_pkg::cic_word_t raw;           // synchronised or internal raw source levels
  cic_pkg::cic_word_t gate;          // source allowed to raise events
  cic_pkg::cic_word_t adj;           // polarity adjusted levels
  cic_pkg::cic_word_t filt;          // after optional debounce
  cic_pkg::cic_word_t evt;           // final event per bit
  logic               summary;       // OR of all flags
  cic_pkg::cic_word_t pin_raw;       // unsynchronised pin levels
  cic_pkg::cic_word_t pin_s1_ff;     // synchroniser stage one
  cic_pkg::cic_word_t pin_s2_ff;     // synchroniser stage two
  cic_pkg::cic_word_t pin_s3_ff;     // synchroniser stage three
  cic_pkg::cic_word_t pin_lvl_ff;    // accepted level once stages two and three agree
  cic_pkg::cic_word_t nxt_pin_lvl;

  // pins come from outside the clock domain; internal statuses do not
  always_comb
  begin
    pin_raw = 16'h0000;
    pin_raw[`CIC_SHARED_PIN_BIT]   = SHARED_PIN_IN;
    pin_raw[`CIC_GP_PIN_ONE_BIT]   = GP_PIN_ONE_IN;
    pin_raw[`CIC_RIGHT_REUSED_BIT] = RIGHT_REUSED_IN;
    pin_raw[`CIC_LEFT_REUSED_BIT]  = LEFT_REUSED_IN;
    // a level counts only when the last two stages agree, filtering metastable flicker
    nxt_pin_lvl = pin_lvl_ff;
    for (int i = 0; i < 16; i++)
    begin
      if (pin_s2_ff[i] == pin_s3_ff[i])
        nxt_pin_lvl[i] = pin_s3_ff[i];
    end
  end

  // synchroniser stages and accepted pin levels, registers only
  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pin_s1_ff  <= 16'h0000;
      pin_s2_ff  <= 16'h0000;
      pin_s3_ff  <= 16'h0000;
      pin_lvl_ff <= 16'h0000;
    end
    else
    begin
      pin_s1_ff  <= pin_raw;
      pin_s2_ff  <= pin_s1_ff;
      pin_s3_ff  <= pin_s2_ff;
      pin_lvl_ff <= nxt_pin_lvl;
    end
  end

  // source levels and gating
  always_comb
  begin
    raw = pin_lvl_ff;
    raw[`CIC_SEQUENCER_BIT]   = SEQUENCER_BUSY;
    raw[`CIC_LOOP_LOCK_BIT]   = LOOP_LOCKED;
    raw[`CIC_BIAS_SHORT_BIT]  = BIAS_SHORT;
    raw[`CIC_BIAS_DETECT_BIT] = BIAS_DETECT;
    gate = SRC;
    // pin sources only raise events while configured as inputs
    gate[`CIC_SHARED_PIN_BIT]   = SHARED_PIN_IS_INPUT;
    gate[`CIC_GP_PIN_ONE_BIT]   = GP_PIN_ONE_IS_INPUT;
    gate[`CIC_RIGHT_REUSED_BIT] = RIGHT_REUSED_ENABLE;
    gate[`CIC_LEFT_REUSED_BIT]  = LEFT_REUSED_ENABLE;
    // inversion applies before the filter so it debounces the active level
    adj = raw ^ pols_ff;
  end

  // one debounce filter per implemented source bit
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_src
      if (SRC[g])
      begin : g_db
        cic_debounce #(
          .CYCLES (DEBOUNCE_CYCLES)
        ) u_db (
          .clk       (CLOCK),
          .rst       (SYS_RST),
          .enable    (deb_ff[g]),
          .level_in  (adj[g]),
          .level_out (filt[g])
        );
      end
      else
      begin : g_none
        assign filt[g] = 1'b0;
      end
    end
  endgenerate

  // a source must be implemented, allowed and active to raise its flag
  assign evt     = filt & gate & SRC;
  assign summary = |flags_ff;

  // register writes, flag latching and interrupt output
  always_comb
  begin
    nxt_flags = flags_ff;
    nxt_masks = masks_ff;
    nxt_pols  = pols_ff;
    nxt_deb   = deb_ff;
    nxt_rdata = rdata_ff;
    if (REG_WR)
    begin
      case (REG_ADDR)
        `CIC_FLAGS_ADDR:
          nxt_flags = flags_ff & ~(REG_WDATA & SRC);
        `CIC_MASKS_ADDR:
          nxt_masks = REG_WDATA & SRC;
        `CIC_POLS_ADDR:
          nxt_pols = REG_WDATA & SRC;
        `CIC_DEBOUNCE_ADDR:
          nxt_deb = REG_WDATA & SRC;
        default:
          nxt_deb = deb_ff;                              // other addresses belong elsewhere
      endcase
    end
    // set applied after clear so a same-cycle event is never lost; masks do not stop it
    nxt_flags = (nxt_flags | evt) & SRC;
    if (REG_RD)
    begin
      case (REG_ADDR)
        `CIC_FLAGS_ADDR:
        begin
          // the sequencer bit may be stale while busy; software must not trust it then
          nxt_rdata = flags_ff;
          nxt_rdata[`CIC_SUMMARY_BIT] = summary;
        end
        `CIC_MASKS_ADDR:    nxt_rdata = masks_ff;
        `CIC_POLS_ADDR:     nxt_rdata = pols_ff;
        `CIC_DEBOUNCE_ADDR: nxt_rdata = deb_ff;
        default:            nxt_rdata = 16'h0000;        // unmapped reads as zero
      endcase
    end
    // output stays high until every unmasked flag is cleared
    nxt_irq = |(nxt_flags & ~nxt_masks);
  end

  // registers only; every reset value is a constant
  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      flags_ff <= 16'h0000;
      masks_ff <= `CIC_MASKS_RESET;
      pols_ff  <= `CIC_POLS_RESET;
      deb_ff   <= `CIC_DEBOUNCE_RESET;
      rdata_ff <= 16'h0000;
      irq_ff   <= 1'b0;
    end
    else
    begin
      flags_ff <= nxt_flags;
      masks_ff <= nxt_masks;
      pols_ff  <= nxt_pols;
      deb_ff   <= nxt_deb;
      rdata_ff <= nxt_rdata;
      irq_ff   <= nxt_irq;
    end
  end

  // both outputs come straight from flip-flops, so no glitch reaches the pin
  assign REG_RDATA = rdata_ff;
  assign IRQ_OUT   = irq_ff;
endmodule : cic_controller

/* tb/cic_controller_sva.sv */
// port checks for the codec interrupt controller
module cic_controller_sva (
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic        SEQUENCER_BUSY,
  input wire logic        LOOP_LOCKED,
  input wire logic        BIAS_DETECT,
  input wire logic        IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] msk_ff; // shadow of the masks
  logic [15:0] pol_ff; // shadow of the polarities
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // shadows tell the irq checks which sources count and how
  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      msk_ff <= 16'h033f;
      pol_ff <= 16'h0000;
    end
    else if (REG_WR && REG_ADDR == 8'h80)
      msk_ff <= REG_WDATA & 16'h033f;
    else if (REG_WR && REG_ADDR == 8'h81)
      pol_ff <= REG_WDATA & 16'h033f;
  end
  a_summary_or_flags: assert property (
    REG_RD && REG_ADDR == 8'h7f |=> REG_RDATA[10] == |REG_RDATA[9:0]) else $error("bad summary");
  a_spare_flags_zero: assert property (
    REG_RD && REG_ADDR == 8'h7f |=> (REG_RDATA & 16'hf8c0) == 16'h0000) else $error("spare set");
  a_unmapped_read_zero: assert property (
    REG_RD && !(REG_ADDR inside {[8'h7f:8'h82]}) |=> REG_RDATA == 16'h0000) else $error("unmapped");
  a_mask_read_back: assert property (
    REG_RD && !REG_WR && REG_ADDR == 8'h80 |=> REG_RDATA == msk_ff) else $error("mask readback");
  a_pol_read_back: assert property (
    REG_RD && !REG_WR && REG_ADDR == 8'h81 |=> REG_RDATA == pol_ff) else $error("pol readback");
  a_detect_raises_irq: assert property (
    (BIAS_DETECT ^ pol_ff[0]) && !msk_ff[0] && !REG_WR |=> IRQ_OUT) else $error("detect irq");
  a_lock_raises_irq: assert property (
    (LOOP_LOCKED ^ pol_ff[2]) && !msk_ff[2] && !REG_WR |=> IRQ_OUT) else $error("lock irq");
  a_seq_raises_irq: assert property (
    (SEQUENCER_BUSY ^ pol_ff[8]) && !msk_ff[8] && !REG_WR |=> IRQ_OUT) else $error("seq irq");
  a_irq_fall_write: assert property (
    $fell(IRQ_OUT) |-> $past(REG_WR)) else $error("irq dropped without a write");
endmodule : cic_controller_sva

bind cic_controller cic_controller_sva u_sva (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .SEQUENCER_BUSY(SEQUENCER_BUSY), .LOOP_LOCKED(LOOP_LOCKED),
  .BIAS_DETECT(BIAS_DETECT), .IRQ_OUT(IRQ_OUT));

/* tb/cic_controller_test.sv */
// self-checking bench for the codec interrupt controller
module cic_controller_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DB = 2; // short debounce keeps the run brief
  logic CLOCK = 0, SYS_RST = 1, REG_WR = 0, REG_RD = 0, IRQ_OUT, rd_pend = 0;
  logic [7:0]  REG_ADDR = 8'h00;
  logic [15:0] REG_WDATA = 16'h0000, REG_RDATA, r, cw;
  logic SHARED_PIN_IN = 0, SEQUENCER_BUSY = 0, GP_PIN_ONE_IN = 0, RIGHT_REUSED_IN = 0;
  logic LEFT_REUSED_IN = 0, LOOP_LOCKED = 0, BIAS_SHORT = 0, BIAS_DETECT = 0, p;
  logic SHARED_PIN_IS_INPUT = 1, GP_PIN_ONE_IS_INPUT = 1, RIGHT_REUSED_ENABLE = 1;
  logic LEFT_REUSED_ENABLE = 1;
  logic [31:0] note_q[$]; // care mask and expected read word
  logic [31:0] note;
  integer miscompares = 0, samples_checked = 0, seed = 68755, b;
  int bits[8] = '{0, 1, 2, 3, 4, 5, 8, 9};
  always #20 CLOCK = ~CLOCK;
  cic_controller #(.DEBOUNCE_CYCLES(DB)) dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .SHARED_PIN_IN(SHARED_PIN_IN), .SEQUENCER_BUSY(SEQUENCER_BUSY),
    .SHARED_PIN_IS_INPUT(SHARED_PIN_IS_INPUT), .GP_PIN_ONE_IN(GP_PIN_ONE_IN),
    .GP_PIN_ONE_IS_INPUT(GP_PIN_ONE_IS_INPUT), .RIGHT_REUSED_IN(RIGHT_REUSED_IN),
    .RIGHT_REUSED_ENABLE(RIGHT_REUSED_ENABLE), .LEFT_REUSED_IN(LEFT_REUSED_IN),
    .LEFT_REUSED_ENABLE(LEFT_REUSED_ENABLE), .LOOP_LOCKED(LOOP_LOCKED),
    .BIAS_SHORT(BIAS_SHORT), .BIAS_DETECT(BIAS_DETECT), .IRQ_OUT(IRQ_OUT));
  task automatic cmp_word(input logic [15:0] e, input logic [15:0] c);
    samples_checked++;
    if ((REG_RDATA & c) !== (e & c))
    begin
      miscompares++;
      $display("FAIL REG_RDATA expected %h seen %h", e, REG_RDATA);
    end
  endtask : cmp_word
  task automatic cmp_irq(input logic e);
    samples_checked++;
    if (IRQ_OUT !== e)
    begin
      miscompares++;
      $display("FAIL IRQ_OUT expected %b seen %b", e, IRQ_OUT);
    end
  endtask : cmp_irq
  // read answers land one edge after the strobe; compare the oldest note
  always @(posedge CLOCK) rd_pend <= REG_RD;
  always @(negedge CLOCK)
  begin
    if (rd_pend && note_q.size() > 0)
    begin
      note = note_q.pop_front();
      cmp_word(note[15:0], note[31:16]);
    end
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge CLOCK);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1;
    @(negedge CLOCK);
    REG_WR = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] c);
    @(negedge CLOCK);
    REG_ADDR = a;
    REG_RD = 1;
    note_q.push_back({c, e});
    @(negedge CLOCK);
    REG_RD = 0;
  endtask : rd
  task automatic w(input int n);
    repeat (n) @(negedge CLOCK);
  endtask : w
  // summary bit added to an expected flag word
  function automatic logic [15:0] fw(input logic [15:0] f);
    return f | {5'h00, |f, 10'h000};
  endfunction : fw
  task automatic drv(input int s, input logic v);
    case (s)
      0: BIAS_DETECT = v;
      1: BIAS_SHORT = v;
      2: LOOP_LOCKED = v;
      3: LEFT_REUSED_IN = v;
      4: RIGHT_REUSED_IN = v;
      5: GP_PIN_ONE_IN = v;
      8: SEQUENCER_BUSY = v;
      default: SHARED_PIN_IN = v;
    endcase
  endtask : drv
  task automatic gate(input logic g);
    {SHARED_PIN_IS_INPUT, GP_PIN_ONE_IS_INPUT, RIGHT_REUSED_ENABLE, LEFT_REUSED_ENABLE} = {4{g}};
  endtask : gate
  task automatic print_verdict;
    $display("compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial
  begin
    #(40 * 6000);
    miscompares++;
    print_verdict();
  end
  initial
  begin
    w(2);
    SYS_RST = 0;
    rd(8'h7f, 16'h0000, 16'hffff);
    rd(8'h80, 16'h033f, 16'hffff);
    rd(8'h81, 16'h0000, 16'hffff);
    rd(8'h55, 16'h0000, 16'hffff);
    cmp_irq(0);
    r = 16'($random(seed));
    wr(8'h80, r);
    rd(8'h80, r & 16'h033f, 16'hffff);
    wr(8'h81, ~r);
    rd(8'h81, ~r & 16'h033f, 16'hffff);
    wr(8'h80, 16'h0000);
    $display("test reset_and_access done");
    // every source in both polarities; the idle level is the inactive one
    for (int pi = 0; pi < 2; pi++)
    begin
      p = pi[0];
      cw = p ? 16'hfeff : 16'hffff; // sequencer bit unreliable while busy
      for (int k = 0; k < 8; k++) drv(bits[k], p);
      wr(8'h81, p ? 16'h033f : 16'h0000);
      w(6);
      wr(8'h7f, 16'h033f);
      for (int k = 0; k < 8; k++)
      begin
        b = bits[k];
        drv(b, ~p);
        w(3);
        drv(b, p);
        w(6);
        cmp_irq(1);
        wr(8'h7f, 16'h033f & ~(16'h1 << b));
        rd(8'h7f, fw(16'h1 << b), cw);
        wr(8'h7f, 16'h1 << b);
        rd(8'h7f, 16'h0000, cw);
        cmp_irq(0);
      end
    end
    $display("test sources_and_polarity done");
    // polarities are still inverted here, so low is the active pin level
    gate(0);
    for (int k = 3; k < 8; k++) if (k != 6) drv(bits[k], 0);
    w(6);
    for (int k = 3; k < 8; k++) if (k != 6) drv(bits[k], 1);
    w(6);
    rd(8'h7f, 16'h0000, 16'hffff);
    gate(1);
    // back to plain polarity with every source idle low and no flag left over
    for (int k = 0; k < 8; k++) drv(bits[k], 0);
    wr(8'h81, 16'h0000);
    w(6);
    wr(8'h7f, 16'h033f);
    rd(8'h7f, 16'h0000, 16'hffff);
    $display("test gated_pins done");
    wr(8'h80, 16'h033f);
    drv(0, 1);
    w(3);
    cmp_irq(0);
    wr(8'h7f, 16'h0001);
    rd(8'h7f, fw(16'h0001), 16'hffff);
    drv(0, 0);
    wr(8'h80, 16'h0000);
    w(1);
    cmp_irq(1);
    wr(8'h7f, 16'h0001);
    wr(8'h80, 16'h033f);
    $display("test masking done");
    wr(8'h82, 16'h0001);
    drv(0, 1);
    w(1);
    drv(0, 0);
    w(6);
    rd(8'h7f, 16'h0000, 16'hffff);
    drv(0, 1);
    w(DB + 3);
    drv(0, 0);
    w(3);
    rd(8'h7f, fw(16'h0001), 16'hffff);
    $display("test debounce done");
    w(2);
    print_verdict();
  end
endmodule : cic_controller_test
